/* File: src/cobpt_defs.vh */
/*
  Constants for the message-object page and phase-timing block.
  Assumes an 8-bit SFR address space and the CAN system clock as clk.
*/
`ifndef COBPT_DEFS_VH
`define COBPT_DEFS_VH
`define COBPT_ADDR_PAGE 8'hB1
`define COBPT_ADDR_STAT 8'hB2
`define COBPT_ADDR_CTRL 8'hB3
`define COBPT_ADDR_BT3 8'hB6
`define COBPT_ADDR_EN 8'hB9
`define COBPT_ADDR_DATA 8'hBA
`define COBPT_PHASE_SEG_TWO_LEN_LSB 4
`define COBPT_PHASE_SEG_ONE_LEN_LSB 1
`define COBPT_SMP_BIT 0
`define COBPT_OBJECT_NUMBER_LSB 4
`define COBPT_INDEX_AUTOINC_N_BIT 3
`define COBPT_WARN_BIT 7
`define COBPT_CFG_OFF 2'h0
`define COBPT_CFG_TX 2'h1
`define COBPT_CFG_RX 2'h2
`define COBPT_CFG_RXBUF 2'h3
`define COBPT_ID_STD_LEN 5'h0B
`define COBPT_ID_EXT_LEN 5'h1D
`endif

/* File: src/cobpt_top.v */
/*
  Page select, per-object control/length/data, and phase-segment bit timing.
  Assumes SFR strobes and frame-complete events come from logic on clk; only can_rx is a pin.
*/
`include "cobpt_defs.vh"
`default_nettype none
module cobpt_top
(
  input wire clk,
  input wire rst_n,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata_r,
  input wire controller_enable_bit,
  input wire [5:0] prescaler_value,
  input wire [1:0] sjw_value,
  input wire [2:0] prop_value,
  input wire can_rx,
  input wire rx_frame_done,
  input wire [1:0] rx_obj,
  input wire [3:0] rx_dlc,
  output reg [3:0] object_enable_bits_r,
  output reg [3:0] length_mismatch_warn_r,
  output reg [3:0] reply_valid_r,
  output reg [3:0] ide_ext_r,
  output reg sample_pulse_r,
  output reg sample_bit_r
);
  localparam ST_SYNC = 2'd0;
  localparam ST_PROP = 2'd1;
  localparam ST_PH1 = 2'd2;
  localparam ST_PH2 = 2'd3;

  reg rst_m_r;
  reg rst_s_r;
  wire rst_sn = rst_s_r;
  reg rx_m_r;
  reg rx_s_r;
  reg rx_prev_r;

  reg [6:0] bt_r;
  reg [5:0] page_r;
  reg [7:0] ctrl_r [0:3];
  reg [7:0] data_mem [0:31];

  reg [5:0] pre_cnt_r;
  reg [1:0] st_r;
  reg [3:0] seg_cnt_r;
  reg [3:0] ext_r;
  reg [3:0] shr_r;
  reg resynced_r;
  reg [2:0] tq_smp_r;

  wire [1:0] obj_sel = page_r[5:4];
  wire [2:0] idx = page_r[2:0];
  wire acc_data = (sfr_wr | sfr_rd) && (sfr_addr == `COBPT_ADDR_DATA);
  wire wr_ctrl = sfr_wr && (sfr_addr == `COBPT_ADDR_CTRL);
  wire wr_stat = sfr_wr && (sfr_addr == `COBPT_ADDR_STAT);
  wire [2:0] phase_seg_two_len = bt_r[6:4];
  wire [2:0] phase_seg_one_len = bt_r[3:1];
  wire triple = bt_r[`COBPT_SMP_BIT];
  wire tq_tick = (pre_cnt_r == prescaler_value);
  wire [3:0] sjw_q = {2'b00, sjw_value} + 4'h1;
  wire edge_fall = rx_prev_r & ~rx_s_r;
  wire [3:0] len_ph1 = {1'b0, phase_seg_one_len} + 4'h1 + ext_r;
  wire [3:0] len_ph2 = {1'b0, phase_seg_two_len} + 4'h1;
  wire ph2_end = ({1'b0, seg_cnt_r} + 5'h01 + {1'b0, shr_r}) >= {1'b0, len_ph2};
  wire maj = (tq_smp_r[0] & tq_smp_r[1]) | (tq_smp_r[0] & tq_smp_r[2]) | (tq_smp_r[1] & tq_smp_r[2]);

  function [4:0] mem_addr;
    input [1:0] obj;
    input [2:0] byte_i;
    begin
      mem_addr = {obj, byte_i};
    end
  endfunction

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end
    else
    begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  // can_rx is asynchronous; only rx_s_r and rx_prev_r are read downstream
  always @(posedge clk or negedge rst_sn)
  begin
    if (!rst_sn)
    begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end
    else
    begin
      rx_m_r <= can_rx;
      rx_s_r <= rx_m_r;
      rx_prev_r <= rx_s_r;
    end
  end

  // register writes and page index stepping
  always @(posedge clk or negedge rst_sn)
  begin
    if (!rst_sn)
    begin
      bt_r <= 7'h00;
      page_r <= 6'h00;
    end
    else
    begin
      // timing writes taken regardless; software gates them on the enable bit
      if (sfr_wr && sfr_addr == `COBPT_ADDR_BT3)
        bt_r <= sfr_wdata[6:0];
      if (sfr_wr && sfr_addr == `COBPT_ADDR_PAGE)
        page_r <= sfr_wdata[5:0];
      else if (acc_data && !page_r[`COBPT_INDEX_AUTOINC_N_BIT])
        page_r[2:0] <= idx + 3'h1;
    end
  end

  // data buffer has no reset: contents undefined until written
  always @(posedge clk)
  begin
    if (sfr_wr && sfr_addr == `COBPT_ADDR_DATA)
      data_mem[mem_addr(obj_sel, idx)] <= sfr_wdata;
  end

  integer k;
  always @(posedge clk or negedge rst_sn)
  begin
    if (!rst_sn)
    begin
      for (k = 0; k < 4; k = k + 1)
        ctrl_r[k] <= 8'h00;
      object_enable_bits_r <= 4'h0;
      length_mismatch_warn_r <= 4'h0;
      reply_valid_r <= 4'h0;
      ide_ext_r <= 4'h0;
    end
    else
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        if (wr_ctrl && obj_sel == k[1:0])
        begin
          ctrl_r[k] <= sfr_wdata;
          // config off frees the object, any other mode enables it
          object_enable_bits_r[k] <= (sfr_wdata[7:6] != `COBPT_CFG_OFF);
          reply_valid_r[k] <= sfr_wdata[5];
          ide_ext_r[k] <= sfr_wdata[4];
        end
        if (rx_frame_done && rx_obj == k[1:0])
          ctrl_r[k][3:0] <= rx_dlc;
        // set beats a software clear in the same cycle
        if (rx_frame_done && rx_obj == k[1:0] && rx_dlc != ctrl_r[k][3:0])
          length_mismatch_warn_r[k] <= 1'b1;
        else if (wr_stat && obj_sel == k[1:0] && !sfr_wdata[`COBPT_WARN_BIT])
          length_mismatch_warn_r[k] <= 1'b0;
      end
    end
  end

  // registered read data, reserved bits read zero
  always @(posedge clk or negedge rst_sn)
  begin
    if (!rst_sn)
      sfr_rdata_r <= 8'h00;
    else if (sfr_rd)
    begin
      case (sfr_addr)
        `COBPT_ADDR_PAGE: sfr_rdata_r <= {2'b00, page_r};
        `COBPT_ADDR_STAT: sfr_rdata_r <= {length_mismatch_warn_r[obj_sel], 7'h00};
        `COBPT_ADDR_CTRL: sfr_rdata_r <= ctrl_r[obj_sel];
        `COBPT_ADDR_BT3: sfr_rdata_r <= {1'b0, bt_r};
        `COBPT_ADDR_EN: sfr_rdata_r <= {4'h0, object_enable_bits_r};
        `COBPT_ADDR_DATA: sfr_rdata_r <= data_mem[mem_addr(obj_sel, idx)];
        default: sfr_rdata_r <= 8'h00;
      endcase
    end
  end

  // bit timing: quantum prescaler, segment sequencer, resync
  always @(posedge clk or negedge rst_sn)
  begin
    if (!rst_sn)
    begin
      pre_cnt_r <= 6'h00;
      st_r <= ST_SYNC;
      seg_cnt_r <= 4'h0;
      ext_r <= 4'h0;
      shr_r <= 4'h0;
      resynced_r <= 1'b0;
      tq_smp_r <= 3'h7;
      sample_pulse_r <= 1'b0;
      sample_bit_r <= 1'b1;
    end
    else if (!controller_enable_bit)
    begin
      pre_cnt_r <= 6'h00;
      st_r <= ST_SYNC;
      seg_cnt_r <= 4'h0;
      ext_r <= 4'h0;
      shr_r <= 4'h0;
      resynced_r <= 1'b0;
      sample_pulse_r <= 1'b0;
    end
    else
    begin
      sample_pulse_r <= 1'b0;
      pre_cnt_r <= tq_tick ? 6'h00 : pre_cnt_r + 6'h01;
      // one resync per bit, always by the full jump width
      if (edge_fall && !resynced_r && st_r == ST_PH1)
      begin
        ext_r <= sjw_q;
        resynced_r <= 1'b1;
      end
      if (edge_fall && !resynced_r && st_r == ST_PH2)
      begin
        shr_r <= sjw_q;
        resynced_r <= 1'b1;
      end
      if (tq_tick)
      begin
        tq_smp_r <= {tq_smp_r[1:0], rx_s_r};
        seg_cnt_r <= seg_cnt_r + 4'h1;
        case (st_r)
          ST_SYNC:
          begin
            st_r <= ST_PROP;
            seg_cnt_r <= 4'h0;
          end
          ST_PROP:
            if (seg_cnt_r == {1'b0, prop_value})
            begin
              st_r <= ST_PH1;
              seg_cnt_r <= 4'h0;
            end
          ST_PH1:
            if (seg_cnt_r + 4'h1 >= len_ph1)
            begin
              st_r <= ST_PH2;
              seg_cnt_r <= 4'h0;
              sample_pulse_r <= 1'b1;
              sample_bit_r <= triple ? maj : rx_s_r;
            end
          ST_PH2:
            if (ph2_end)
            begin
              st_r <= ST_SYNC;
              seg_cnt_r <= 4'h0;
              ext_r <= 4'h0;
              shr_r <= 4'h0;
              resynced_r <= 1'b0;
            end
          default:
            st_r <= ST_SYNC;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/cobpt_top_properties.sv */
/* port checker for cobpt_top
   assumes one clock domain, bound to the top module */
`default_nettype none
module cobpt_top_properties
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata_r,
  input wire logic controller_enable_bit,
  input wire logic [3:0] object_enable_bits_r,
  input wire logic [3:0] length_mismatch_warn_r,
  input wire logic [3:0] reply_valid_r,
  input wire logic [3:0] ide_ext_r,
  input wire logic sample_pulse_r,
  input wire logic sample_bit_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] obj_r;
  sequence s_ctl_wr;
    sfr_wr && sfr_addr == 8'hB3;
  endsequence
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      obj_r <= 2'h0;
    else if (sfr_wr && sfr_addr == 8'hB1)
      obj_r <= sfr_wdata[5:4];
  a_enable_follows_cfg: assert property (s_ctl_wr |=>
    object_enable_bits_r[obj_r] == ($past(sfr_wdata[7:6]) != 2'h0)) else $error("enable bit wrong");
  a_reply_ide_bits: assert property (s_ctl_wr |=>
    {reply_valid_r[obj_r], ide_ext_r[obj_r]} == $past(sfr_wdata[5:4])) else $error("control bits wrong");
  a_warn_sticky: assert property (!(sfr_wr && sfr_addr == 8'hB2) |=>
    (length_mismatch_warn_r & $past(length_mismatch_warn_r)) == $past(length_mismatch_warn_r))
    else $error("warning dropped");
  a_pulse_spacing: assert property (sample_pulse_r |=> !sample_pulse_r [*2])
    else $error("sample points too close");
  a_idle_no_sample: assert property (!controller_enable_bit [*2] |=> !sample_pulse_r)
    else $error("sampling while disabled");
  a_bit_at_sample: assert property ($changed(sample_bit_r) |-> sample_pulse_r)
    else $error("sampled bit moved off sample point");
  a_enable_readback: assert property (sfr_rd && sfr_addr == 8'hB9 |=>
    sfr_rdata_r == {4'h0, $past(object_enable_bits_r)}) else $error("enable readback wrong");
  a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata_r))
    else $error("read data moved without read");
endmodule
bind cobpt_top cobpt_top_properties cobpt_top_properties_i (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_r(sfr_rdata_r),
  .controller_enable_bit(controller_enable_bit), .object_enable_bits_r(object_enable_bits_r),
  .length_mismatch_warn_r(length_mismatch_warn_r), .reply_valid_r(reply_valid_r), .ide_ext_r(ide_ext_r),
  .sample_pulse_r(sample_pulse_r), .sample_bit_r(sample_bit_r));
`default_nettype wire

/* File: verification/cobpt_bus_node.sv */
/* far-side node on the shared bus
   assumes the bench says when it pulls the bus dominant */
`default_nettype none
module cobpt_bus_node
(
  input wire logic dominant,
  output logic can_rx
);
  timeunit 1ns;
  timeprecision 100ps;
  // a released bus rests at the recessive pull-up level
  assign can_rx = dominant ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: verification/tb_cobpt_top.sv */
/* self-checking bench for cobpt_top
   assumes the bus node model and the bound checker */
`default_nettype none
module tb_cobpt_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, en = 0, rxd = 0, dom = 0, can_rx, rd_d = 0;
  logic [7:0] addr = 0, wd = 0, rdata, q[$], ctl[4], dat[4][8];
  logic [5:0] presc = 0;
  logic [1:0] robj = 0;
  logic [3:0] rdlc = 0, enb, warn, rv, ide;
  logic pulse_r, sbit;
  int errors = 0, checks = 0, cyc = 0, t;
  always #2.5 clk = ~clk;
  cobpt_bus_node cobpt_bus_node_i (.dominant(dom), .can_rx(can_rx));
  cobpt_top cobpt_top_i (.clk(clk), .rst_n(rst_n), .sfr_addr(addr), .sfr_wdata(wd), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata_r(rdata), .controller_enable_bit(en), .prescaler_value(presc),
    .sjw_value(2'h0), .prop_value(3'h0), .can_rx(can_rx), .rx_frame_done(rxd), .rx_obj(robj), .rx_dlc(rdlc),
    .object_enable_bits_r(enb), .length_mismatch_warn_r(warn), .reply_valid_r(rv), .ide_ext_r(ide),
    .sample_pulse_r(pulse_r), .sample_bit_r(sbit));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_wr <= w;
    sfr_rd <= !w;
    addr <= a;
    wd <= d;
    if (!w)
      q.push_back(d);
    @(posedge clk);
    sfr_wr <= 0;
    sfr_rd <= 0;
  endtask
  task frame(input logic [1:0] o, input logic [3:0] l);
    @(posedge clk);
    rxd <= 1;
    robj <= o;
    rdlc <= l;
    @(posedge clk);
    rxd <= 0;
  endtask
  task pulse;
    do @(posedge clk); while (pulse_r !== 1'b1);
  endtask
  task period(input logic [7:0] bt, input logic [5:0] p, input logic [7:0] exp);
    @(posedge clk);
    en <= 0;
    presc <= p;
    acc(1, 8'hB6, bt);
    acc(0, 8'hB6, bt & 8'h7F);
    @(posedge clk);
    en <= 1;
    pulse();
    t = cyc;
    pulse();
    check(8'(cyc - t), exp);
  endtask
  always @(posedge clk)
  begin
    rd_d <= sfr_rd;
    cyc <= cyc + 1;
    if (rd_d)
      check(rdata, q.pop_front());
    if (cyc == 6000)
    begin
      errors++;
      stop_test();
    end
  end
  initial
  begin
    void'($urandom(50901));
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    acc(0, 8'hB1, 8'h00);
    acc(0, 8'hB3, 8'h00);
    acc(0, 8'h00, 8'h00);
    for (int o = 0; o < 4; o++)
    begin
      acc(1, 8'hB1, {2'h0, 2'(o), 4'h0});
      for (int i = 0; i < 8; i++)
      begin
        dat[o][i] = 8'($urandom);
        acc(1, 8'hBA, dat[o][i]);
      end
      acc(0, 8'hB1, {2'h0, 2'(o), 4'h0});
      ctl[o] = {2'(o), 2'($urandom), 4'($urandom % 9)};
      acc(1, 8'hB3, ctl[o]);
    end
    for (int o = 0; o < 4; o++)
    begin
      acc(1, 8'hB1, {2'h0, 2'(o), 4'h0});
      acc(0, 8'hB3, ctl[o]);
      for (int i = 0; i < 8; i++)
        acc(0, 8'hBA, dat[o][i]);
    end
    acc(0, 8'hB9, 8'h0E);
    acc(1, 8'hB1, 8'h1D);
    acc(0, 8'hBA, dat[1][5]);
    acc(0, 8'hBA, dat[1][5]);
    acc(0, 8'hB1, 8'h1D);
    frame(2, ctl[2][3:0] ^ 4'h1);
    frame(3, ctl[3][3:0]);
    acc(1, 8'hB1, 8'h20);
    acc(0, 8'hB2, 8'h80);
    acc(0, 8'hB3, ctl[2] ^ 8'h01);
    acc(1, 8'hB2, 8'h00);
    acc(0, 8'hB2, 8'h00);
    acc(1, 8'hB1, 8'h30);
    acc(0, 8'hB2, 8'h00);
    // phase 2 kept at two quanta or more: below that software breaks the timing rule
    period(8'h10, 6'h00, 8'd5);
    period(8'h22, 6'h01, 8'd14);
    period(8'h7E, 6'h02, 8'd54);
    period(8'h11, 6'h00, 8'd5);
    dom <= 1;
    repeat (4) pulse();
    check({7'h0, sbit}, 8'h00);
    dom <= 0;
    repeat (4) pulse();
    check({7'h0, sbit}, 8'h01);
    // mid-run reset: page and enables must come back cleared
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    acc(0, 8'hB1, 8'h00);
    acc(0, 8'hB9, 8'h00);
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule
`default_nettype wire
